// *** verilog/anreg_bank.sv ***
// Auto-negotiation register bank with APB slave and engine port
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps

// How it works
// RULE1 - Soft reset bit 15, clears itself
// RULE2 - Enable bit 12, resets set, control 0x1000
// RULE3 - Restart bit 9 pulses, clears itself
// RULE4 - Page-arrived flag sticky, cleared writing zero
// RULE5 - Done bit 5 mirrors negotiation completion
// RULE6 - Far-end fault flag sticky, cleared writing zero
// RULE7 - Capable bit 3 always one, status 0x8
// RULE8 - Base page bits 12:5 software writable
// RULE9 - Nonce 20:16, abilities 47:21 writable
// RULE10 - Partner base page in three words
// RULE11 - Toggle device managed, ack reads zero
// RULE12 - Partner next page control and code stored
module anreg_bank
  import anreg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        page_rx_valid,
  input  wire logic        page_rx_is_next,
  input  wire logic [47:0] page_rx_data,
  input  wire logic        np_sent,
  input  wire logic        an_done,
  input  wire logic        fault_detect,
  input  wire logic        link_up,
  output logic             negotiation_soft_reset,
  output logic             negotiation_enable,
  output logic             negotiation_restart,
  output logic      [47:0] local_base_page,
  output logic      [47:0] local_next_page
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic        page_arrived_flag;
  logic        fault_flag;
  logic        negotiation_done;
  logic        link_q;
  logic [47:0] partner_base;
  logic [31:0] partner_next;
  logic        next_soft_reset;
  logic        next_enable;
  logic        next_restart;
  logic        next_page_flag;
  logic        next_fault_flag;
  logic        next_done;
  logic        next_link;
  logic [47:0] next_lbp;
  logic [47:0] next_lnp;
  logic [47:0] next_pbp;
  logic [31:0] next_pnp;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        hit;
  logic        wr_en;
  logic        lo_ok;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Only the low 16 bits hold data; both low lanes must be enabled
  assign wdata = pwdata[15:0];
  assign lo_ok = pstrb[1] & pstrb[0];
  assign wr_en = psel & penable & pready & pwrite & hit & lo_ok;

  // Read mux and address hit
  always_comb
  begin
    hit   = 1'b1;
    rdata = 16'h0000;
    case (paddr[11:2])
      IDX_CONTROL:
      begin
        rdata[CTRL_SOFT_RESET_BIT] = negotiation_soft_reset;
        rdata[CTRL_ENABLE_BIT]     = negotiation_enable;
        rdata[CTRL_RESTART_BIT]    = negotiation_restart;
      end
      IDX_STATUS:
      begin
        rdata[STAT_PAGE_BIT]    = page_arrived_flag;
        rdata[STAT_DONE_BIT]    = negotiation_done;     // [RULE5]
        rdata[STAT_FAULT_BIT]   = fault_flag;
        rdata[STAT_CAPABLE_BIT] = 1'b1;                 // [RULE7]
        rdata[STAT_LINK_BIT]    = link_q;
      end
      IDX_LBP_LOW:  rdata = local_base_page[15:0];
      IDX_LBP_MID:  rdata = local_base_page[31:16];
      IDX_LBP_HIGH: rdata = local_base_page[47:32];
      IDX_PBP_LOW:  rdata = partner_base[15:0];         // [RULE10]
      IDX_PBP_MID:  rdata = partner_base[31:16];        // [RULE10]
      IDX_PBP_HIGH: rdata = partner_base[47:32];        // [RULE10]
      IDX_LNP_LOW:  rdata = local_next_page[15:0];
      IDX_LNP_MID:  rdata = local_next_page[31:16];
      IDX_LNP_HIGH: rdata = local_next_page[47:32];
      IDX_PNP_LOW:  rdata = partner_next[15:0];
      IDX_PNP_MID:  rdata = partner_next[31:16];
      default:      hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Hardware set beats software clear on every sticky flag
  always_comb
  begin
    next_soft_reset = 1'b0;                             // [RULE1]
    next_restart    = 1'b0;                             // [RULE3]
    next_enable     = negotiation_enable;
    next_page_flag  = page_arrived_flag;
    next_fault_flag = fault_flag;
    next_done       = an_done;                          // [RULE5]
    next_link       = link_up;
    next_lbp        = local_base_page;
    next_lnp        = local_next_page;
    next_pbp        = partner_base;
    next_pnp        = partner_next;
    // Register writes
    if (wr_en)
    begin
      case (paddr[11:2])
        IDX_CONTROL:
        begin
          next_soft_reset = wdata[CTRL_SOFT_RESET_BIT]; // [RULE1]
          next_enable     = wdata[CTRL_ENABLE_BIT];     // [RULE2]
          next_restart    = wdata[CTRL_RESTART_BIT];    // [RULE3]
        end
        IDX_STATUS:
        begin
          if (!wdata[STAT_PAGE_BIT])
            next_page_flag = 1'b0;                      // [RULE4]
          if (!wdata[STAT_FAULT_BIT])
            next_fault_flag = 1'b0;                     // [RULE6]
        end
        IDX_LBP_LOW:
        begin
          next_lbp[15:0]        = wdata;                // [RULE8]
          next_lbp[BP_ACK_BIT]  = 1'b0;                 // [RULE11]
        end
        IDX_LBP_MID:  next_lbp[31:16] = wdata;          // [RULE9]
        IDX_LBP_HIGH: next_lbp[47:32] = wdata;          // [RULE9]
        IDX_LNP_LOW:
        begin
          next_lnp[15:0]          = wdata;
          next_lnp[NP_RSVD_BIT]   = 1'b0;
          next_lnp[NP_TOGGLE_BIT] = local_next_page[NP_TOGGLE_BIT];
        end
        IDX_LNP_MID:  next_lnp[31:16] = wdata;
        IDX_LNP_HIGH: next_lnp[47:32] = wdata;
        default:      next_enable = negotiation_enable;
      endcase
    end
    // Toggle alternates on each next page sent
    if (np_sent)
      next_lnp[NP_TOGGLE_BIT] = ~local_next_page[NP_TOGGLE_BIT]; // [RULE11]
    // Engine events, set after clear so set wins
    if (page_rx_valid)
    begin
      next_page_flag = 1'b1;                            // [RULE4]
      if (page_rx_is_next)
        next_pnp = page_rx_data[31:0];                  // [RULE12]
      else
        next_pbp = page_rx_data;                        // [RULE10]
    end
    if (fault_detect)
      next_fault_flag = 1'b1;                           // [RULE6]
    // Soft reset drops negotiation state but keeps configuration
    if (negotiation_soft_reset)
    begin
      next_page_flag          = 1'b0;                   // [RULE1]
      next_fault_flag         = 1'b0;
      next_lnp[NP_TOGGLE_BIT] = 1'b0;
    end
  end

  // APB answer: one access cycle, no wait states
  always_comb
  begin
    next_pready  = psel & ~penable & ~pready;
    next_pslverr = psel & ~penable & ~pready
                   & (~hit | (pwrite & ~lo_ok));
    next_prdata  = prdata;
    if (psel & ~penable & ~pready & ~pwrite)
      next_prdata = {16'h0000, rdata};
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      negotiation_soft_reset <= CONTROL_RESET[CTRL_SOFT_RESET_BIT];
      negotiation_enable     <= CONTROL_RESET[CTRL_ENABLE_BIT];  // [RULE2]
      negotiation_restart    <= CONTROL_RESET[CTRL_RESTART_BIT];
      page_arrived_flag      <= STATUS_RESET[STAT_PAGE_BIT];
      fault_flag             <= STATUS_RESET[STAT_FAULT_BIT];
      negotiation_done       <= STATUS_RESET[STAT_DONE_BIT];
      link_q                 <= STATUS_RESET[STAT_LINK_BIT];
      local_base_page        <= LBP_RESET;
      local_next_page        <= PAGE_ZERO;
      partner_base           <= PAGE_ZERO;
      partner_next           <= PAGE_ZERO[31:0];
      prdata                 <= 32'h0000_0000;
      pready                 <= 1'b0;
      pslverr                <= 1'b0;
    end
    else
    begin
      negotiation_soft_reset <= next_soft_reset;
      negotiation_enable     <= next_enable;
      negotiation_restart    <= next_restart;
      page_arrived_flag      <= next_page_flag;
      fault_flag             <= next_fault_flag;
      negotiation_done       <= next_done;
      link_q                 <= next_link;
      local_base_page        <= next_lbp;
      local_next_page        <= next_lnp;
      partner_base           <= next_pbp;
      partner_next           <= next_pnp;
      prdata                 <= next_prdata;
      pready                 <= next_pready;
      pslverr                <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence ctrl_write_s;
    wr_en && paddr[11:2] == IDX_CONTROL;
  endsequence

  sequence status_zero_page_s;
    wr_en && paddr[11:2] == IDX_STATUS && !wdata[STAT_PAGE_BIT];
  endsequence

  soft_reset_clear_a : assert property ( // [RULE1]
    negotiation_soft_reset |=> !negotiation_soft_reset
      && !page_arrived_flag)
    else $error("soft reset bit did not clear itself");

  enable_write_a : assert property ( // [RULE2]
    ctrl_write_s |=> negotiation_enable == $past(wdata[CTRL_ENABLE_BIT]))
    else $error("enable bit did not follow write");

  restart_pulse_a : assert property ( // [RULE3]
    ctrl_write_s and wdata[CTRL_RESTART_BIT] |=> negotiation_restart
      ##1 !negotiation_restart)
    else $error("restart bit not a one-cycle pulse");

  page_flag_set_a : assert property ( // [RULE4]
    page_rx_valid && !negotiation_soft_reset |=> page_arrived_flag)
    else $error("page arrival not flagged");

  page_flag_clear_a : assert property ( // [RULE4]
    status_zero_page_s ##0 !page_rx_valid ##0 !negotiation_soft_reset
      |=> !page_arrived_flag)
    else $error("page flag not cleared by zero write");

  // Both directions: a stuck done bit must also fail
  done_mirror_a : assert property ( // [RULE5]
    1'b1 |=> negotiation_done == $past(an_done))
    else $error("done bit does not mirror completion");

  fault_hold_a : assert property ( // [RULE6]
    fault_flag && !wr_en && !negotiation_soft_reset |=> fault_flag)
    else $error("fault flag lost without clear");

  status_read_a : assert property ( // [RULE7]
    psel && !penable && !pready && !pwrite
      && paddr[11:2] == IDX_STATUS |=> prdata[STAT_CAPABLE_BIT])
    else $error("capable bit not read as one");

  base_write_a : assert property ( // [RULE8]
    wr_en && paddr[11:2] == IDX_LBP_LOW
      |=> local_base_page[12:5] == $past(wdata[12:5]))
    else $error("base page bits 12:5 not written");

  ack_zero_a : assert property ( // [RULE11]
    !local_base_page[BP_ACK_BIT])
    else $error("base page acknowledge not zero");

  toggle_flip_a : assert property ( // [RULE11]
    np_sent && !negotiation_soft_reset |=> local_next_page[NP_TOGGLE_BIT]
      != $past(local_next_page[NP_TOGGLE_BIT]))
    else $error("next page toggle did not alternate");

  partner_capture_a : assert property ( // [RULE10]
    page_rx_valid && !page_rx_is_next
      |=> partner_base == $past(page_rx_data))
    else $error("partner base page not captured");

  partner_next_a : assert property ( // [RULE12]
    page_rx_valid && page_rx_is_next
      |=> partner_next == $past(page_rx_data[31:0]))
    else $error("partner next page not captured");

endmodule

// *** include/anreg_pkg.sv ***
// Package: register indices, field positions and reset values
package anreg_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_CONTROL     = 10'h200;
  localparam logic [9:0] IDX_STATUS      = 10'h201;
  localparam logic [9:0] IDX_LBP_LOW     = 10'h202;
  localparam logic [9:0] IDX_LBP_MID     = 10'h203;
  localparam logic [9:0] IDX_LBP_HIGH    = 10'h204;
  localparam logic [9:0] IDX_PBP_LOW     = 10'h205;
  localparam logic [9:0] IDX_PBP_MID     = 10'h206;
  localparam logic [9:0] IDX_PBP_HIGH    = 10'h207;
  localparam logic [9:0] IDX_LNP_LOW     = 10'h208;
  localparam logic [9:0] IDX_LNP_MID     = 10'h209;
  localparam logic [9:0] IDX_LNP_HIGH    = 10'h20A;
  localparam logic [9:0] IDX_PNP_LOW     = 10'h20B;
  localparam logic [9:0] IDX_PNP_MID     = 10'h20C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SOFT_RESET_BIT = 15;
  localparam int CTRL_ENABLE_BIT     = 12;
  localparam int CTRL_RESTART_BIT    = 9;
  localparam int STAT_PAGE_BIT       = 6;
  localparam int STAT_DONE_BIT       = 5;
  localparam int STAT_FAULT_BIT      = 4;
  localparam int STAT_CAPABLE_BIT    = 3;
  localparam int STAT_LINK_BIT       = 2;
  localparam int BP_ACK_BIT          = 14;
  localparam int NP_RSVD_BIT         = 14;
  localparam int NP_TOGGLE_BIT       = 11;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CONTROL_RESET = 16'h1000;
  localparam logic [15:0] STATUS_RESET  = 16'h0008;
  localparam logic [47:0] LBP_RESET     = 48'h0000_0000_0001;
  localparam logic [47:0] PAGE_ZERO     = 48'h0000_0000_0000;

endpackage

// *** test/anreg_engine_model.sv ***
// Behavioural negotiation engine driving the bank's engine port
`timescale 1ns/100ps
module anreg_engine_model
(
  input  wire logic        pclk,
  input  wire logic        negotiation_soft_reset,
  input  wire logic        negotiation_restart,
  output logic             page_rx_valid,
  output logic             page_rx_is_next,
  output logic      [47:0] page_rx_data,
  output logic             np_sent,
  output logic             an_done,
  output logic             fault_detect,
  output logic             link_up
);
  // Quiet engine at time zero
  initial
  begin
    page_rx_valid   = 1'b0;
    page_rx_is_next = 1'b0;
    page_rx_data    = 48'h0;
    np_sent         = 1'b0;
    an_done         = 1'b0;
    fault_detect    = 1'b0;
    link_up         = 1'b0;
  end
  // A restart or reset of negotiation drops completion
  always @(posedge pclk)
    if (negotiation_soft_reset === 1'b1 || negotiation_restart === 1'b1)
      an_done <= 1'b0;
  // One page strobe; data is scrambled once strobe drops, not held
  task automatic send_page(input logic nxt, input logic [47:0] d);
    @(posedge pclk);
    page_rx_valid   <= 1'b1;
    page_rx_is_next <= nxt;
    page_rx_data    <= d;
    @(posedge pclk);
    page_rx_valid <= 1'b0;
    page_rx_data  <= ~d;
  endtask
  // One-cycle strobes and levels from the engine
  task automatic pulse(input logic is_fault);
    @(posedge pclk);
    np_sent      <= ~is_fault;
    fault_detect <= is_fault;
    @(posedge pclk);
    np_sent      <= 1'b0;
    fault_detect <= 1'b0;
  endtask
  task automatic set_levels(input logic done, input logic link);
    @(posedge pclk);
    an_done <= done;
    link_up <= link;
  endtask
endmodule

// *** test/tb_anreg_bank.sv ***
// Self-checking bench for the negotiation register bank
`timescale 1ns/100ps
module tb_anreg_bank;
  import anreg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        page_rx_valid, page_rx_is_next, np_sent, an_done;
  logic        fault_detect, link_up, soft_rst, enable, restart;
  logic [47:0] page_rx_data, lbp, lnp;
  logic [15:0] r;
  logic        e;
  int          bad_count = 0, cmp_count = 0;
  int          restart_cnt = 0, sreset_cnt = 0;
  logic [15:0] rv [13] = '{16'h1000, 16'h0008, 16'h0001, 16'h0, 16'h0,
    16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};

  anreg_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .page_rx_valid(page_rx_valid), .page_rx_is_next(page_rx_is_next),
    .page_rx_data(page_rx_data), .np_sent(np_sent), .an_done(an_done),
    .fault_detect(fault_detect), .link_up(link_up),
    .negotiation_soft_reset(soft_rst), .negotiation_enable(enable),
    .negotiation_restart(restart), .local_base_page(lbp),
    .local_next_page(lnp));
  anreg_engine_model eng (.pclk(pclk), .negotiation_soft_reset(soft_rst),
    .negotiation_restart(restart), .page_rx_valid(page_rx_valid),
    .page_rx_is_next(page_rx_is_next), .page_rx_data(page_rx_data),
    .np_sent(np_sent), .an_done(an_done), .fault_detect(fault_detect),
    .link_up(link_up));

  // ------------------------------------------------------------
  // Clock, strobe counters and shared tasks
  // ------------------------------------------------------------
  always #20 pclk = ~pclk;
  // Counting cycles high also catches a strobe that sticks
  always @(posedge pclk)
  begin
    if (restart === 1'b1)
      restart_cnt <= restart_cnt + 1;
    if (soft_rst === 1'b1)
      sreset_cnt <= sreset_cnt + 1;
  end
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Request held until pready is sampled high, released after
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [15:0] d, output logic [15:0] rd_v, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      bad_count++;
      end_of_test;
    end
    rd_v = prdata[15:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] i, input logic [15:0] d);
    apb(1'b1, {i, 2'b00}, d, r, e);
  endtask
  task automatic rd(input logic [9:0] i, input logic [15:0] x);
    apb(1'b0, {i, 2'b00}, 16'h0000, r, e);
    check({32'h0, r}, {32'h0, x});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {pclk, presetn, psel, penable, pwrite} = 5'h00;
    {paddr, pwdata, pstrb} = {12'h000, 32'h0, 4'hF};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 13; i++)
      rd(IDX_CONTROL + 10'(i), rv[i]);
    apb(1'b0, 12'h834, 16'h0000, r, e);
    check(48'(e), 48'h1);
    $display("reset values and unmapped read done");
    wr(IDX_CONTROL, 16'h1200);
    rd(IDX_CONTROL, 16'h1000);
    check(48'(restart_cnt), 48'h1);
    wr(IDX_CONTROL, 16'h0000);
    // Let the committing edge update the register first
    @(posedge pclk);
    check(48'(enable), 48'h0);
    rd(IDX_CONTROL, 16'h0000);
    wr(IDX_CONTROL, 16'h1000);
    $display("control test done");
    wr(IDX_LBP_LOW, 16'hFFFF);
    rd(IDX_LBP_LOW, 16'hBFFF);
    wr(IDX_LBP_MID, 16'hA5C3);
    wr(IDX_LBP_HIGH, 16'h5A3C);
    @(posedge pclk);
    check(lbp, 48'h5A3C_A5C3_BFFF);
    // Write with the low lanes off is refused and leaves data alone
    pstrb <= 4'hC;
    apb(1'b1, {IDX_LBP_MID, 2'b00}, 16'h1111, r, e);
    check(48'(e), 48'h1);
    pstrb <= 4'hF;
    rd(IDX_LBP_MID, 16'hA5C3);
    $display("local base page test done");
    eng.send_page(1'b0, 48'h1234_5678_9ABC);
    rd(IDX_PBP_LOW, 16'h9ABC);
    rd(IDX_PBP_MID, 16'h5678);
    rd(IDX_PBP_HIGH, 16'h1234);
    rd(IDX_STATUS, 16'h0048);
    wr(IDX_STATUS, 16'hFFFF);
    rd(IDX_STATUS, 16'h0048);
    wr(IDX_STATUS, 16'h0000);
    rd(IDX_STATUS, 16'h0008);
    $display("partner base page test done");
    wr(IDX_LNP_LOW, 16'hFFFF);
    rd(IDX_LNP_LOW, 16'hB7FF);
    check(lnp, 48'h0000_0000_B7FF);
    eng.pulse(1'b0);
    rd(IDX_LNP_LOW, 16'hBFFF);
    eng.send_page(1'b1, 48'h0000_ABCD_F123);
    rd(IDX_PNP_LOW, 16'hF123);
    rd(IDX_PNP_MID, 16'hABCD);
    $display("next page test done");
    eng.set_levels(1'b1, 1'b1);
    eng.pulse(1'b1);
    rd(IDX_STATUS, 16'h007C);
    wr(IDX_STATUS, 16'h0000);
    rd(IDX_STATUS, 16'h002C);
    $display("status test done");
    eng.pulse(1'b1);
    wr(IDX_CONTROL, 16'h9000);
    // Pulse lands on the committing edge, the count one edge later
    repeat (2) @(posedge pclk);
    check(48'(sreset_cnt), 48'h1);
    rd(IDX_CONTROL, 16'h1000);
    rd(IDX_STATUS, 16'h000C);
    rd(IDX_LNP_LOW, 16'hB7FF);
    $display("soft reset test done");
    end_of_test;
  end
endmodule
